// ---- verilog/lal_pkg.sv ----
// constants for the level arbitration, analog output and relay logic
// assumes one 25 MHz clock and a one-cycle measurement-cycle tick from the processor
// Behaviour
// [RULE1] level input faulty below minimum or above 21.0 mA
// [RULE2] valid current scaled linearly to elevation, 4 to 20 mA
// [RULE3] lower-numbered assigned input is the primary
// [RULE4] primary within minimum..19.8 mA alone gives level
// [RULE5] primary low: use secondary if within minimum..20.0 mA
// [RULE6] both inputs low: no level, section failed
// [RULE7] primary above 19.8 mA, secondary good: larger wins
// [RULE8] primary above limit, secondary rejected: primary used
// [RULE9] analog output linear between 4 mA and 20 mA extremes
// [RULE10] on fault output goes 4 mA or holds
// [RULE11] under-range drives 4 mA, over-range 20 mA
// [RULE12] outside measurement mode outputs hold last value; the code holds only ao_code, and the three relays keep switching
// [RULE13] threshold relay trips after delay consecutive exceeding cycles
// [RULE14] threshold relay resets after delay consecutive cycles below
// [RULE15] failed section forces threshold relay to normal
// [RULE16] threshold compare is signed
// [RULE17] status relay trips after delay, clears at once
// [RULE18] path fault after bad-measurement limit cycles without data
// [RULE19] totalizer relay pulses 100 ms per whole unit
// [RULE20] at most one totalizer pulse per cycle, rest owed
// [RULE21] one totalizer relay per section
// [RULE22] units owed from an outage paid once per cycle
// [RULE23] delay counters clear when trigger condition absent
package lal_pkg;
    // register byte offsets
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_MIN_CUR = 6'h04;
    localparam logic [5:0] REG_LOW_ELEV = 6'h08;
    localparam logic [5:0] REG_HIGH_ELEV = 6'h0c;
    localparam logic [5:0] REG_AO_LO = 6'h10;
    localparam logic [5:0] REG_AO_HI = 6'h14;
    localparam logic [5:0] REG_THRESH = 6'h18;
    localparam logic [5:0] REG_DELAY = 6'h1c;
    localparam logic [5:0] REG_BAD_LIMIT = 6'h20;
    localparam logic [5:0] REG_STATUS = 6'h24;
    localparam logic [5:0] REG_LEVEL = 6'h28;
    localparam logic [5:0] REG_AO_CODE = 6'h2c;
    // control bit positions
    localparam int CTRL_MEASURE = 0;
    localparam int CTRL_HOLD_ON_ERR = 1;
    localparam int CTRL_AO_LEVEL = 2;
    localparam int CTRL_THR_LEVEL = 3;
    localparam int CTRL_THR_POL = 4;
    localparam int CTRL_STAT_POL = 5;
    localparam int CTRL_TOT_POL = 6;
    localparam int CTRL_DUAL = 7;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] MIN_CUR_RST = 16'h0ed8;
    // currents in microamps
    localparam logic [15:0] CUR_4MA = 16'h0fa0;
    localparam logic [15:0] CUR_FAULT_HI = 16'h5208;
    localparam logic [15:0] CUR_ARB_HI = 16'h4d58;
    localparam logic [15:0] CUR_SEC_HI = 16'h4e20;
    localparam logic signed [47:0] CUR_SPAN = 48'sh000000003e80;
    // analog output codes for 4 mA and 20 mA
    localparam logic [15:0] AO_CODE_4MA = 16'h1999;
    localparam logic [15:0] AO_CODE_20MA = 16'h7fff;
    // totalizer pulse
    localparam int CLK_HZ = 25_000_000;
    localparam int TOT_PULSE_MS = 100;
    localparam int TOT_PULSE_CYC = CLK_HZ / 1000 * TOT_PULSE_MS;
endpackage : lal_pkg

// ---- verilog/lal_level_alarm.sv ----
// per-section level arbitration, analog output mapping and relay drive
// assumes inputs come from logic on i_clk; i_meas_tick marks one measurement cycle
//
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module lal_level_alarm #(
    parameter int PULSE_CYCLES = lal_pkg::TOT_PULSE_CYC
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_meas_tick,
    input wire logic [15:0] i_lvl1_ua,
    input wire logic [15:0] i_lvl2_ua,
    input wire logic signed [23:0] i_flow,
    input wire logic i_path_nodata,
    input wire logic [7:0] i_vol_units,
    output logic [15:0] o_ao_code,
    output logic o_thr_relay,
    output logic o_stat_relay,
    output logic o_tot_relay,
    output logic o_section_fail
);

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [7:0] ctrl;
        logic [15:0] min_cur;
        logic signed [23:0] low_elev;
        logic signed [23:0] high_elev;
        logic signed [23:0] ao_lo;
        logic signed [23:0] ao_hi;
        logic signed [23:0] thresh;
        logic [7:0] delay;
        logic [7:0] bad_limit;
        logic lvl1_fault;
        logic lvl2_fault;
        logic sec_fail;
        logic path_fault;
        logic signed [23:0] level;
        logic [7:0] bad_cnt;
        logic [15:0] ao_code;
        logic thr_trip;
        logic [7:0] thr_cnt;
        logic stat_trip;
        logic [7:0] stat_cnt;
        logic [15:0] owed;
        logic tot_act;
        logic [21:0] tot_cnt;
        logic thr_out;
        logic stat_out;
        logic tot_out;
    } lal_state_type;

    lal_state_type st_ff;
    lal_state_type nxt_st;
    logic signed [23:0] sc1;
    logic signed [23:0] sc2;

    // ****************************************
    // current to elevation scaling
    // ****************************************
    function automatic logic signed [23:0] scale_cur(input logic [15:0] cur, input logic signed [23:0] lo,
                                                     input logic signed [23:0] hi);
        logic signed [47:0] prod;
        prod = ($signed({32'h0, cur}) - $signed({32'h0, lal_pkg::CUR_4MA})) * (48'(hi) - 48'(lo));
        scale_cur = 24'(48'(lo) + prod / lal_pkg::CUR_SPAN); // [RULE2]
    endfunction : scale_cur

    assign sc1 = scale_cur(i_lvl1_ua, st_ff.low_elev, st_ff.high_elev);
    assign sc2 = scale_cur(i_lvl2_ua, st_ff.low_elev, st_ff.high_elev);

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        logic rej1;
        logic rej2;
        logic fault_now;
        logic exceed;
        logic signed [23:0] v;
        logic signed [47:0] num;
        logic signed [47:0] den;
        logic signed [47:0] q;
        logic under;
        logic over;
        logic [15:0] owed_sum;
        rej1 = 1'b0;
        rej2 = 1'b0;
        fault_now = 1'b0;
        exceed = 1'b0;
        v = '0;
        num = '0;
        den = '0;
        q = '0;
        under = 1'b0;
        over = 1'b0;
        owed_sum = '0;
        nxt_st = st_ff;

        // bus slave, one wait state
        nxt_st.ack = (i_avs_read | i_avs_write) & ~st_ff.ack;
        if (i_avs_read && !st_ff.ack) begin
            if (i_avs_address == lal_pkg::REG_CTRL) begin
                nxt_st.rdata = {24'h0, st_ff.ctrl};
            end else if (i_avs_address == lal_pkg::REG_MIN_CUR) begin
                nxt_st.rdata = {16'h0, st_ff.min_cur};
            end else if (i_avs_address == lal_pkg::REG_LOW_ELEV) begin
                nxt_st.rdata = 32'(st_ff.low_elev);
            end else if (i_avs_address == lal_pkg::REG_HIGH_ELEV) begin
                nxt_st.rdata = 32'(st_ff.high_elev);
            end else if (i_avs_address == lal_pkg::REG_AO_LO) begin
                nxt_st.rdata = 32'(st_ff.ao_lo);
            end else if (i_avs_address == lal_pkg::REG_AO_HI) begin
                nxt_st.rdata = 32'(st_ff.ao_hi);
            end else if (i_avs_address == lal_pkg::REG_THRESH) begin
                nxt_st.rdata = 32'(st_ff.thresh);
            end else if (i_avs_address == lal_pkg::REG_DELAY) begin
                nxt_st.rdata = {24'h0, st_ff.delay};
            end else if (i_avs_address == lal_pkg::REG_BAD_LIMIT) begin
                nxt_st.rdata = {24'h0, st_ff.bad_limit};
            end else if (i_avs_address == lal_pkg::REG_STATUS) begin
                nxt_st.rdata = {st_ff.owed, 6'h0, st_ff.tot_out, st_ff.stat_out, st_ff.thr_out,
                                st_ff.tot_act, st_ff.stat_trip, st_ff.thr_trip, st_ff.path_fault,
                                st_ff.sec_fail, st_ff.lvl2_fault, st_ff.lvl1_fault};
            end else if (i_avs_address == lal_pkg::REG_LEVEL) begin
                nxt_st.rdata = 32'(st_ff.level);
            end else if (i_avs_address == lal_pkg::REG_AO_CODE) begin
                nxt_st.rdata = {16'h0, st_ff.ao_code};
            end else begin
                nxt_st.rdata = 32'h0;
            end
        end
        if (i_avs_write && st_ff.ack) begin
            if (i_avs_address == lal_pkg::REG_CTRL) begin
                nxt_st.ctrl = i_avs_writedata[7:0];
            end else if (i_avs_address == lal_pkg::REG_MIN_CUR) begin
                nxt_st.min_cur = i_avs_writedata[15:0];
            end else if (i_avs_address == lal_pkg::REG_LOW_ELEV) begin
                nxt_st.low_elev = i_avs_writedata[23:0];
            end else if (i_avs_address == lal_pkg::REG_HIGH_ELEV) begin
                nxt_st.high_elev = i_avs_writedata[23:0];
            end else if (i_avs_address == lal_pkg::REG_AO_LO) begin
                nxt_st.ao_lo = i_avs_writedata[23:0];
            end else if (i_avs_address == lal_pkg::REG_AO_HI) begin
                nxt_st.ao_hi = i_avs_writedata[23:0];
            end else if (i_avs_address == lal_pkg::REG_THRESH) begin
                nxt_st.thresh = i_avs_writedata[23:0];
            end else if (i_avs_address == lal_pkg::REG_DELAY) begin
                nxt_st.delay = i_avs_writedata[7:0];
            end else if (i_avs_address == lal_pkg::REG_BAD_LIMIT) begin
                nxt_st.bad_limit = i_avs_writedata[7:0];
            end
        end

        // ****************************************
        // measurement cycle
        // ****************************************
        rej1 = (i_lvl1_ua < st_ff.min_cur) || (i_lvl1_ua > lal_pkg::CUR_FAULT_HI); // [RULE1]
        rej2 = !st_ff.ctrl[lal_pkg::CTRL_DUAL] || (i_lvl2_ua < st_ff.min_cur)
               || (i_lvl2_ua > lal_pkg::CUR_FAULT_HI); // [RULE1]
        if (i_meas_tick) begin
            nxt_st.lvl1_fault = rej1;
            nxt_st.lvl2_fault = rej2;
            nxt_st.sec_fail = 1'b0;
            // input 1 is always the lower-numbered one of the pair [RULE3]
            if (!rej1 && i_lvl1_ua <= lal_pkg::CUR_ARB_HI) begin
                nxt_st.level = sc1; // [RULE4]
            end else if (rej1) begin
                if (!rej2 && i_lvl2_ua <= lal_pkg::CUR_SEC_HI) begin
                    nxt_st.level = sc2; // [RULE5]
                end else begin
                    nxt_st.sec_fail = 1'b1; // [RULE6]
                end
            end else if (!rej2) begin
                nxt_st.level = (sc2 > sc1) ? sc2 : sc1; // [RULE7]
            end else begin
                nxt_st.level = sc1; // [RULE8]
            end

            // path data watchdog
            if (i_path_nodata) begin
                if (st_ff.bad_cnt >= st_ff.bad_limit) begin
                    nxt_st.path_fault = 1'b1; // [RULE18]
                end else begin
                    nxt_st.bad_cnt = st_ff.bad_cnt + 8'h01;
                end
            end else begin
                nxt_st.bad_cnt = '0;
                nxt_st.path_fault = 1'b0;
            end
            fault_now = nxt_st.sec_fail | nxt_st.path_fault;

            // analog output
            v = st_ff.ctrl[lal_pkg::CTRL_AO_LEVEL] ? nxt_st.level : i_flow;
            num = 48'(v) - 48'(st_ff.ao_lo);
            den = 48'(st_ff.ao_hi) - 48'(st_ff.ao_lo);
            if (den > 0) begin
                under = v < st_ff.ao_lo;
                over = v > st_ff.ao_hi;
            end else begin
                under = (v > st_ff.ao_lo) || (den == 0);
                over = v < st_ff.ao_hi;
            end
            if (st_ff.ctrl[lal_pkg::CTRL_MEASURE]) begin // [RULE12]
                if (fault_now) begin
                    if (!st_ff.ctrl[lal_pkg::CTRL_HOLD_ON_ERR]) begin
                        nxt_st.ao_code = lal_pkg::AO_CODE_4MA; // [RULE10]
                    end
                end else if (under) begin
                    nxt_st.ao_code = lal_pkg::AO_CODE_4MA; // [RULE11]
                end else if (over) begin
                    nxt_st.ao_code = lal_pkg::AO_CODE_20MA; // [RULE11]
                end else begin
                    // signed span keeps reverse ranges (hi below lo) correct
                    q = num * $signed(48'(lal_pkg::AO_CODE_20MA - lal_pkg::AO_CODE_4MA)) / den;
                    nxt_st.ao_code = 16'(48'(lal_pkg::AO_CODE_4MA) + q); // [RULE9]
                end
            end

            // threshold relay, signed compare [RULE16]
            exceed = (st_ff.ctrl[lal_pkg::CTRL_THR_LEVEL] ? nxt_st.level : i_flow) >= st_ff.thresh;
            if (nxt_st.sec_fail) begin
                nxt_st.thr_trip = 1'b0; // [RULE15]
                nxt_st.thr_cnt = '0;
            end else if (exceed != st_ff.thr_trip) begin
                if (st_ff.thr_cnt >= st_ff.delay) begin
                    nxt_st.thr_trip = exceed; // [RULE13] [RULE14]
                    nxt_st.thr_cnt = '0;
                end else begin
                    nxt_st.thr_cnt = st_ff.thr_cnt + 8'h01;
                end
            end else begin
                nxt_st.thr_cnt = '0; // [RULE23]
            end

            // status relay
            if (!fault_now) begin
                nxt_st.stat_trip = 1'b0; // [RULE17]
                nxt_st.stat_cnt = '0; // [RULE23]
            end else if (st_ff.stat_cnt >= st_ff.delay) begin
                nxt_st.stat_trip = 1'b1; // [RULE17]
            end else begin
                nxt_st.stat_cnt = st_ff.stat_cnt + 8'h01;
            end

            // totalizer: units owed, at most one paid per cycle [RULE20] [RULE22]
            owed_sum = st_ff.owed + {8'h0, i_vol_units};
            if (owed_sum < st_ff.owed) begin
                owed_sum = 16'hffff;
            end
            if (owed_sum != 16'h0 && !st_ff.tot_act) begin
                owed_sum = owed_sum - 16'h0001;
                nxt_st.tot_act = 1'b1; // [RULE19]
                nxt_st.tot_cnt = '0;
            end
            nxt_st.owed = owed_sum;
        end
        if (st_ff.tot_act && !(i_meas_tick && nxt_st.tot_cnt == '0 && st_ff.tot_cnt == '0)) begin
            if (st_ff.tot_cnt >= 22'(PULSE_CYCLES - 1)) begin
                nxt_st.tot_act = 1'b0; // [RULE19]
            end else begin
                nxt_st.tot_cnt = st_ff.tot_cnt + 22'h1;
            end
        end

        // single relay per function per section [RULE21]
        nxt_st.thr_out = nxt_st.thr_trip ^ nxt_st.ctrl[lal_pkg::CTRL_THR_POL];
        nxt_st.stat_out = nxt_st.stat_trip ^ nxt_st.ctrl[lal_pkg::CTRL_STAT_POL];
        nxt_st.tot_out = nxt_st.tot_act ^ nxt_st.ctrl[lal_pkg::CTRL_TOT_POL];
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st_ff <= '0;
            st_ff.ctrl <= lal_pkg::CTRL_RST;
            st_ff.min_cur <= lal_pkg::MIN_CUR_RST;
            st_ff.ao_code <= lal_pkg::AO_CODE_4MA;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~st_ff.ack;
    assign o_avs_readdata = st_ff.rdata;
    assign o_ao_code = st_ff.ao_code;
    assign o_thr_relay = st_ff.thr_out;
    assign o_stat_relay = st_ff.stat_out;
    assign o_tot_relay = st_ff.tot_out;
    assign o_section_fail = st_ff.sec_fail;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    property p_lvl_fault;
        i_meas_tick && (i_lvl1_ua < st_ff.min_cur) |=> st_ff.lvl1_fault;
    endproperty
    a_lvl_fault: assert property (p_lvl_fault) else $error("low input not flagged"); // [RULE1]

    property p_primary;
        i_meas_tick && !rej_chk(i_lvl1_ua, st_ff.min_cur) && (i_lvl1_ua <= lal_pkg::CUR_ARB_HI)
        |=> st_ff.level == $past(sc1);
    endproperty
    a_primary: assert property (p_primary) else $error("primary level not used"); // [RULE4]

    property p_both_low;
        i_meas_tick && st_ff.ctrl[lal_pkg::CTRL_DUAL] && (i_lvl1_ua < st_ff.min_cur)
        && (i_lvl2_ua < st_ff.min_cur) |=> st_ff.sec_fail ##1 o_section_fail;
    endproperty
    a_both_low: assert property (p_both_low) else $error("section not failed"); // [RULE6]

    property p_greater;
        i_meas_tick && st_ff.ctrl[lal_pkg::CTRL_DUAL] && (i_lvl1_ua > lal_pkg::CUR_ARB_HI)
        && !rej_chk(i_lvl1_ua, st_ff.min_cur) && !rej_chk(i_lvl2_ua, st_ff.min_cur)
        |=> st_ff.level >= $past(sc2) && st_ff.level >= $past(sc1);
    endproperty
    a_greater: assert property (p_greater) else $error("larger level not chosen"); // [RULE7]

    property p_fault_4ma;
        i_meas_tick && st_ff.ctrl[lal_pkg::CTRL_MEASURE] && !st_ff.ctrl[lal_pkg::CTRL_HOLD_ON_ERR]
        && nxt_st.sec_fail |=> o_ao_code == lal_pkg::AO_CODE_4MA;
    endproperty
    a_fault_4ma: assert property (p_fault_4ma) else $error("fault output not 4 mA"); // [RULE10]

    property p_hold;
        !st_ff.ctrl[lal_pkg::CTRL_MEASURE] |=> o_ao_code == $past(o_ao_code);
    endproperty
    a_hold: assert property (p_hold) else $error("output moved outside measure mode"); // [RULE12]

    property p_fail_normal;
        st_ff.sec_fail |-> !st_ff.thr_trip && o_thr_relay == st_ff.ctrl[lal_pkg::CTRL_THR_POL];
    endproperty
    a_fail_normal: assert property (p_fail_normal) else $error("relay tripped while failed"); // [RULE15]

    property p_stat_clear;
        i_meas_tick && !nxt_st.sec_fail && !nxt_st.path_fault |=> !st_ff.stat_trip;
    endproperty
    a_stat_clear: assert property (p_stat_clear) else $error("status relay not cleared"); // [RULE17]

    property p_pulse_len;
        $rose(st_ff.tot_act) |-> st_ff.tot_act[*8];
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("totalizer pulse too short"); // [RULE19]

    property p_over_range;
        i_meas_tick && st_ff.ctrl[lal_pkg::CTRL_MEASURE] && !nxt_st.sec_fail && !nxt_st.path_fault
        && (st_ff.ao_hi > st_ff.ao_lo) && (i_flow > st_ff.ao_hi) && !st_ff.ctrl[lal_pkg::CTRL_AO_LEVEL]
        |=> o_ao_code == lal_pkg::AO_CODE_20MA;
    endproperty
    a_over_range: assert property (p_over_range) else $error("over-range output not 20 mA"); // [RULE11]

    property p_path_clear;
        i_meas_tick && !i_path_nodata |=> !st_ff.path_fault && (st_ff.bad_cnt == '0);
    endproperty
    a_path_clear: assert property (p_path_clear) else $error("path fault not cleared by data"); // [RULE18]

    c_arb_max: cover property (i_meas_tick && st_ff.ctrl[lal_pkg::CTRL_DUAL] && i_lvl1_ua > lal_pkg::CUR_ARB_HI);
    c_thr_trip: cover property ($rose(st_ff.thr_trip));
    c_tot_pulse: cover property ($fell(st_ff.tot_act));
    c_path_fault: cover property ($rose(st_ff.path_fault));

    function automatic logic rej_chk(input logic [15:0] cur, input logic [15:0] min_cur);
        rej_chk = (cur < min_cur) || (cur > lal_pkg::CUR_FAULT_HI);
    endfunction : rej_chk

endmodule : lal_level_alarm
`default_nettype wire

// ---- sim/lal_field.sv ----
// field side model: two level transmitters and a totalizer pulse counter
// assumes currents commanded by the bench and a relay driven by the design
`timescale 1ns/100ps
`default_nettype none
module lal_field (
    input wire logic i_clk,
    input wire logic [15:0] i_cmd1,
    input wire logic [15:0] i_cmd2,
    input wire logic i_tot_relay,
    output var logic [15:0] o_lvl1_ua,
    output var logic [15:0] o_lvl2_ua,
    output var int o_pulses
);
    logic last_ff = 1'b0;
    initial begin
        o_lvl1_ua = 16'h0fa0;
        o_lvl2_ua = 16'h0fa0;
        o_pulses = 0;
    end
    // ***************************************
    // loop current settles a clock after the command
    // ***************************************
    always @(posedge i_clk) begin
        o_lvl1_ua <= i_cmd1;
        o_lvl2_ua <= i_cmd2;
        last_ff <= i_tot_relay;
        if (i_tot_relay && !last_ff) begin
            o_pulses <= o_pulses + 1;
        end
    end
endmodule : lal_field
`default_nettype wire

// ---- sim/tb.sv ----
// self-checking bench: avalon master tasks, tick driver and reference model
// assumes lal_pkg, lal_level_alarm and the field model lal_field
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int PW = 20;
    localparam int DLY = 2;
    localparam int LIM = 3;
    logic clk = 0, rst = 1, rd = 0, wr = 0, tick = 0, nod = 0, wt, thr, stat, tot, sfail;
    logic [5:0] adr = '0;
    logic [7:0] ctl = '0, units = '0;
    logic [15:0] c1 = 16'h0fa0, c2 = 16'h0fa0, u1, u2, ao, lf = 16'h003f;
    logic [31:0] wd = '0, q, rdat;
    logic signed [23:0] flow = '0;
    int err_count = 0, checks_done = 0, pulses, thv = 8000, lvl = 0, tcnt = 0, scnt = 0, pcnt = 0;
    int owed = 0, npul = 0, aoe = 'h1999;
    bit tt = 0, ts = 0, fl = 0, pf = 0, aok = 1, pul;
    int ta[] = '{10000, 9000, 0, 0, 20500, 20600, 0, 0, 20500, 3000, 0, 0, 3000, 12000, 0, 1,
        21500, 12000, 0, 0, 3000, 3000, 0, 2, 3000, 20500, 0, 0, 3000, 3000, 0, 0, 3800, 4000, 0, 0,
        21000, 3000, 0, 0, 12000, 0, 1, 0, 12000, 0, 1, 0, 12000, 0, 1, 0, 12000, 0, 1, 0, 12000, 0, 1, 0,
        12000, 0, 1, 0, 12000, 0, 0, 0, 12000, 0, 0, 5, 12000, 0, 0, 0, 12000, 0, 0, 0, 12000, 0, 0, 0};
    int tc[] = '{4100, 0, 0, 0, 4100, 0, 0, 0, 4100, 0, 0, 0, 3900, 0, 0, 0, 3900, 0, 0, 0, 3900, 0, 0, 0,
        20000, 0, 0, 0};
    lal_level_alarm #(.PULSE_CYCLES(PW)) lal_level_alarm_i (.i_clk(clk), .i_reset(rst), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wt),
        .i_meas_tick(tick), .i_lvl1_ua(u1), .i_lvl2_ua(u2), .i_flow(flow), .i_path_nodata(nod),
        .i_vol_units(units), .o_ao_code(ao), .o_thr_relay(thr), .o_stat_relay(stat), .o_tot_relay(tot),
        .o_section_fail(sfail));
    lal_field lal_field_i (.i_clk(clk), .i_cmd1(c1), .i_cmd2(c2), .i_tot_relay(tot), .o_lvl1_ua(u1),
        .o_lvl2_ua(u2), .o_pulses(pulses));
    initial begin
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        stop_test();
    end
    // ***************************************
    // tasks and reference model
    // ***************************************
    function automatic logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction : rnd
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (e !== s) begin
            err_count++;
            $display("BAD %s expected %0h seen %0h", n, e, s);
        end
    endtask : chk
    task automatic bus(input bit w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wt !== 1'b0 && n < 40);
        q = rdat;
        rd <= 0;
        wr <= 0;
        if (n >= 40) begin
            err_count++;
            stop_test();
        end
    endtask : bus
    task automatic step(input int a1, input int a2, input bit nd, input int un, input logic [7:0] c);
        bit pb, sb;
        int v, av;
        if (c !== ctl) begin
            ctl = c;
            bus(1, lal_pkg::REG_CTRL, {24'h0, c});
        end
        @(posedge clk);
        c1 <= 16'(a1);
        c2 <= 16'(a2);
        nod <= nd;
        units <= 8'(un);
        flow <= 24'(signed'(rnd()));
        repeat (2) @(posedge clk);
        tick <= 1;
        @(posedge clk);
        tick <= 0;
        pb = a1 < 3800 || a1 > 21000;
        sb = !ctl[7] || a2 < 3800 || a2 > 21000;
        fl = 0;
        if (!pb && a1 <= 19800) lvl = a1 - 4000;
        else if (pb && !sb && a2 <= 20000) lvl = a2 - 4000;
        else if (pb) fl = 1;
        else lvl = (!sb && a2 > a1) ? a2 - 4000 : a1 - 4000;
        pcnt = nd ? pcnt + 1 : 0;
        pf = pcnt > LIM;
        scnt = (fl || pf) ? scnt + 1 : 0;
        ts = scnt > DLY;
        v = ctl[3] ? lvl : int'(flow);
        tcnt = (!fl && (tt ? v < thv : v >= thv)) ? tcnt + 1 : 0;
        tt = fl ? 0 : (tcnt > DLY) ? !tt : tt;
        tcnt = (tcnt > DLY) ? 0 : tcnt;
        if (ctl[0] && (fl || pf) && !ctl[1]) begin
            aoe = lal_pkg::AO_CODE_4MA;
            aok = 1;
        end else if (ctl[0] && !(fl || pf)) begin
            av = ctl[2] ? lvl : int'(flow);
            aoe = av <= 0 ? lal_pkg::AO_CODE_4MA : av >= 16000 ? lal_pkg::AO_CODE_20MA
                : lal_pkg::AO_CODE_4MA + av * (lal_pkg::AO_CODE_20MA - lal_pkg::AO_CODE_4MA) / 16000;
        end
        owed += un;
        pul = owed > 0;
        owed -= pul;
        npul += pul;
        @(posedge clk);
        chk("fail", fl, sfail);
        chk("thr relay", tt ^ ctl[4], thr);
        chk("stat relay", ts ^ ctl[5], stat);
        chk("tot relay", pul, tot);
        if (aok) chk("ao code", aoe, ao);
        bus(0, lal_pkg::REG_LEVEL, 0);
        if (!fl) chk("level", lvl, q);
        bus(0, lal_pkg::REG_STATUS, 0);
        chk("owed", owed, q[31:16]);
        chk("faults", {pf, fl, pb}, {q[3:2], q[0]});
        repeat (PW) @(posedge clk);
        chk("tot end", 0, tot);
    endtask : step
    // ***************************************
    // main sequence
    // ***************************************
    initial begin
        repeat (16) @(posedge clk);
        rst <= 0;
        bus(0, lal_pkg::REG_CTRL, 0);
        chk("ctrl reset", lal_pkg::CTRL_RST, q);
        bus(0, lal_pkg::REG_MIN_CUR, 0);
        chk("min reset", lal_pkg::MIN_CUR_RST, q);
        bus(0, 6'h30, 0);
        chk("unmapped", 0, q);
        bus(1, lal_pkg::REG_LEVEL, 32'h0000_1234);
        bus(0, lal_pkg::REG_LEVEL, 0);
        chk("ro level", 0, q);
        bus(1, lal_pkg::REG_LOW_ELEV, 0);
        bus(1, lal_pkg::REG_HIGH_ELEV, 16000);
        bus(1, lal_pkg::REG_AO_LO, 0);
        bus(1, lal_pkg::REG_AO_HI, 16000);
        bus(1, lal_pkg::REG_THRESH, thv);
        bus(1, lal_pkg::REG_DELAY, DLY);
        bus(1, lal_pkg::REG_BAD_LIMIT, LIM);
        for (int i = 0; i < ta.size(); i += 4) step(ta[i], ta[i + 1], ta[i + 2], ta[i + 3], 8'h8d);
        thv = -60;
        bus(1, lal_pkg::REG_THRESH, thv);
        for (int i = 0; i < tc.size(); i += 4) step(tc[i], tc[i + 1], tc[i + 2], tc[i + 3], 8'hbd);
        step(3000, 3000, 0, 0, 8'hbf);
        step(3000, 3000, 0, 0, 8'hbf);
        step(3900, 0, 0, 0, 8'hbc);
        for (int i = 0; i < 40; i++) begin
            step(3000 + int'(rnd() % 20000), 3000 + int'(rnd() % 17000), rnd() % 8 == 0, int'(rnd() % 3), 8'h81);
        end
        chk("pulse count", npul, pulses);
        stop_test();
    end
endmodule : tb
`default_nettype wire
